// [rtl/cdma_pkg.sv]
// Purpose: shared constants for the core datapath and data-memory addressing block
// Assumes: byte-wide special registers reached by direct address 80H..FFH
// Notes:   register offsets and field positions live here; reset values here cover cfg, psw, sp and page only
package cdma_pkg;
  // special register offsets, identical in both register pages
  localparam logic [7:0] SFR_SP      = 8'h81;
  localparam logic [7:0] SFR_DPL     = 8'h82;
  localparam logic [7:0] SFR_DPH     = 8'h83;
  localparam logic [7:0] SFR_SECOND_POINTER_LOW    = 8'h84;
  localparam logic [7:0] SFR_SECOND_POINTER_HIGH    = 8'h85;
  localparam logic [7:0] SFR_INSCFG  = 8'h86;
  localparam logic [7:0] SFR_PSW     = 8'hD0;
  localparam logic [7:0] SFR_ACC     = 8'hE0;
  localparam logic [7:0] SFR_B       = 8'hF0;
  localparam logic [7:0] SFR_AUX     = 8'hF1;
  localparam logic [7:0] SFR_EXTERNAL_RAM_PAGE   = 8'hF7;
  // instruction_config fields
  localparam int         CFG_PSEL    = 0;
  localparam int         CFG_MULW    = 2;
  localparam int         CFG_DIVW    = 3;
  localparam int         CFG_PAGE    = 6;
  localparam logic [7:0] CFG_MASK    = 8'h4D;
  // program_status_word fields
  localparam int         PSW_CY      = 7;
  localparam int         PSW_AC      = 6;
  localparam int         PSW_RS      = 3;
  localparam int         PSW_OV      = 2;
  localparam int         PSW_P       = 0;
  localparam logic [7:0] PSW_WMASK   = 8'hFE;
  // reset values and masks
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [7:0] PSW_RST     = 8'h00;
  localparam logic [7:0] SP_RST      = 8'h07;
  localparam logic [7:0] EXTERNAL_RAM_PAGE_RST   = 8'h00;
  localparam logic [7:0] EXTERNAL_RAM_PAGE_MASK  = 8'h7F;
  localparam logic [7:0] LOW_RAM_TOP = 8'h7F;
  // memory sizes: external data RAM followed by the display RAM
  localparam int         IRAM_DEPTH  = 256;
  localparam int         XRAM_BYTES  = 1280;
  localparam logic [15:0] DISP_FIRST = 16'h0500;
  localparam logic [15:0] DISP_LAST  = 16'h051B;
  localparam int         XMEM_DEPTH  = 1308;
  localparam int         XIDX_W      = 11;
endpackage

// [rtl/cdma_md_if.sv]
// Purpose: operands and results between the core and the multiply/divide unit
// Assumes: unit is purely combinational
// Notes:   both result sets are offered every cycle; the core picks one
`timescale 1ns/1ps
interface cdma_md_if;
  logic [7:0] acc, bReg, aux;
  logic       mulWide, divWide;
  logic [7:0] mA, mB, mX, dA, dB, dX;
  logic       mOv, dOv;
  modport core (output acc, bReg, aux, mulWide, divWide,
                input mA, mB, mX, dA, dB, dX, mOv, dOv);
  modport unit (input acc, bReg, aux, mulWide, divWide,
                output mA, mB, mX, dA, dB, dX, mOv, dOv);
endinterface // cdma_md_if

// [rtl/cdma_muldiv.sv]
// Purpose: 8/16-bit by 8-bit multiply and divide
// Assumes: operands stable for the cycle the core commits the result
// Notes:   divide by zero leaves operands unchanged and flags overflow
`timescale 1ns/1ps
module cdma_muldiv (
  // operands and results
  cdma_md_if.unit md
);
  import cdma_pkg::*;
  logic [15:0] mOpnd, dOpnd, quot;
  logic [23:0] prod;
  logic [7:0]  rem;
  // narrow mode clears the high operand byte so aux takes no part
  always_comb begin
    mOpnd = md.mulWide ? {md.aux, md.acc} : {8'h00, md.acc};
    dOpnd = md.divWide ? {md.aux, md.acc} : {8'h00, md.acc};
    prod  = mOpnd * {8'h00, md.bReg};
    quot  = (md.bReg == 8'h00) ? dOpnd : dOpnd / {8'h00, md.bReg};
    rem   = (md.bReg == 8'h00) ? md.bReg : 8'((dOpnd % {8'h00, md.bReg}));
  end
  // result routing per width
  assign md.mA  = prod[7:0];
  assign md.mB  = prod[15:8];
  assign md.mX  = md.mulWide ? prod[23:16] : md.aux;
  assign md.mOv = md.mulWide ? (prod[23:8] != 16'h0000) : (prod[15:8] != 8'h00);
  assign md.dA  = (md.bReg == 8'h00) ? md.acc : quot[7:0];
  assign md.dB  = rem;
  assign md.dX  = (md.divWide && md.bReg != 8'h00) ? quot[15:8] : md.aux;
  assign md.dOv = (md.bReg == 8'h00);
endmodule // cdma_muldiv

// [rtl/cdma_dataram.sv]
// Purpose: internal data RAM and external data RAM with display area
// Assumes: one access per array per cycle, read data one cycle later
// Notes:   no reset on the arrays; contents are undefined until written
`timescale 1ns/1ps
module cdma_dataram (
  // clock
  input  wire logic              sys_clk,
  // internal RAM port
  input  wire logic              iWe,
  input  wire logic [7:0]        iAddr,
  input  wire logic [7:0]        iWdata,
  output logic      [7:0]        iRdata,
  // external RAM port
  input  wire logic              xWe,
  input  wire logic [10:0]       xIdx,
  input  wire logic [7:0]        xWdata,
  output logic      [7:0]        xRdata
);
  import cdma_pkg::*;
  logic [7:0] iram [IRAM_DEPTH];
  logic [7:0] xram [XMEM_DEPTH];
  // internal RAM, write-first is not needed by any caller
  always_ff @(posedge sys_clk) begin
    if (iWe) begin
      iram[iAddr] <= iWdata;
    end
    iRdata <= iram[iAddr];
  end
  // external RAM, writes are already range-checked by the caller; reads use the index as given
  always_ff @(posedge sys_clk) begin
    if (xWe) begin
      xram[xIdx] <= xWdata;
    end
    xRdata <= xram[xIdx];
  end
endmodule // cdma_dataram

// [rtl/cdma_top.sv]
// Purpose: core register file extensions and data-memory address decode
// Assumes: the sequencer issues at most one operation request per cycle
// Notes:   read data appears on the cycle after the request
// How it works
// - bank field picks 8-byte working-register window at 00H, 08H, 10H or 18H.
// - parity flag always equals the odd-ones test of the accumulator.
// - narrow multiply puts product low byte in A, high byte in B.
// - wide multiply takes aux:A times B, result into A, B, aux.
// - narrow divide puts quotient in A and remainder in B.
// - wide divide of aux:A: quotient low A, high aux, remainder B.
// - both width bits clear at reset, giving classic 8-bit operations.
// - aux register is plain scratch except in wide multiply or divide.
// - second data pointer has separately writable high and low bytes.
// - pointer-select bit chooses which pointer all pointer operations use.
// - page-select bit chooses special-register page 0 or 1, resets to 0.
// - RAM 00H..7FH is reachable both directly and indirectly.
// - RAM 80H..FFH is reachable only through indirect addressing.
// - special registers 80H..FFH are reachable only by direct addressing.
// - above 7FH the addressing mode alone picks RAM or registers.
// - 1280 bytes of external RAM are reached only by external moves.
// - byte-pointer moves reach 32K bytes through the page register, word pointer reaches everything.
// - page register has seven bits, top bit reads zero, resets to zero.
// - 28 display bytes sit at external addresses 500H..51BH.
// - stack pointer pre-increments on push, post-decrements on pop, resets 07H.
`timescale 1ns/1ps
module cdma_top (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // internal data access
  input  wire logic [7:0]   dAddr,
  input  wire logic         dIndirect,
  input  wire logic         dWr,
  input  wire logic         dRd,
  input  wire logic [7:0]   dWdata,
  output logic      [7:0]   dRdata,
  output logic              dSfrOther,
  output logic              sfrPage,
  // working registers
  input  wire logic [2:0]   wrIdx,
  output logic      [7:0]   wrAddr,
  // stack
  input  wire logic         pushReq,
  input  wire logic         popReq,
  // external moves
  input  wire logic         xWr,
  input  wire logic         xRd,
  input  wire logic         xViaPtr,
  input  wire logic [7:0]   xRi,
  input  wire logic [7:0]   xWdata,
  output logic      [15:0]  xAddr,
  output logic      [7:0]   xRdata,
  output logic              xMiss,
  output logic              xDisplay,
  // instruction operations
  input  wire logic         mulReq,
  input  wire logic         divReq,
  input  wire logic         addReq,
  input  wire logic [7:0]   addOperand,
  input  wire logic         addWithCarry,
  input  wire logic         dptrInc,
  // state views
  output logic      [15:0]  dptr,
  output logic      [7:0]   accOut,
  output logic      [7:0]   pswOut
);
  import cdma_pkg::*;

  logic [7:0] acc_q, b_q, aux_q, psw_q, sp_q, cfg_q, external_ram_page_q;
  logic [7:0] dpl_q, dph_q, second_pointer_low_q, second_pointer_high_q;
  logic [7:0] iRdata, xRam, sfrRd, sfrRd_q, ramAddr, spInc;
  logic       fromSfr_q, iWe, xHit, xWe, dSfr, parity;
  logic [15:0] selPtr, ptrNext;
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic       addOv, addCin;
  cdma_md_if  md ();

  // direct above 7FH goes to registers, indirect always to RAM
  assign dSfr    = !dIndirect && (dAddr > LOW_RAM_TOP);
  assign parity  = ^acc_q;
  assign wrAddr  = {3'b000, psw_q[PSW_RS+1:PSW_RS], wrIdx};
  assign sfrPage = cfg_q[CFG_PAGE];
  assign accOut  = acc_q;
  assign pswOut  = {psw_q[7:1], parity};
  assign spInc   = sp_q + 8'h01;

  // selected data pointer
  assign selPtr  = cfg_q[CFG_PSEL] ? {second_pointer_high_q, second_pointer_low_q} : {dph_q, dpl_q};
  assign ptrNext = selPtr + 16'h0001;
  assign dptr    = selPtr;

  // add with signed overflow; carry computed on the 9-bit sum, auxiliary carry on the 5-bit low-nibble sum
  assign addCin  = addWithCarry & psw_q[PSW_CY];
  assign sum     = {1'b0, acc_q} + {1'b0, addOperand} + {8'h00, addCin};
  assign lowSum  = {1'b0, acc_q[3:0]} + {1'b0, addOperand[3:0]} + {4'h0, addCin};
  assign addOv   = (acc_q[7] == addOperand[7]) && (sum[7] != acc_q[7]);

  // multiply/divide operands
  assign md.acc     = acc_q;
  assign md.bReg    = b_q;
  assign md.aux     = aux_q;
  assign md.mulWide = cfg_q[CFG_MULW];
  assign md.divWide = cfg_q[CFG_DIVW];

  cdma_muldiv uMd (
    .md (md.unit)
  );

  // RAM port: stack has priority over data access
  always_comb begin
    if (pushReq) begin
      ramAddr = spInc;
    end else if (popReq) begin
      ramAddr = sp_q;
    end else begin
      ramAddr = dAddr;
    end
  end
  assign iWe = pushReq || (!popReq && dWr && !dSfr);

  // external address: byte pointer concatenates the page above it
  assign xAddr    = xViaPtr ? selPtr : {external_ram_page_q, xRi};
  assign xDisplay = (xAddr >= DISP_FIRST) && (xAddr <= DISP_LAST);
  assign xHit     = (xAddr < 16'(XRAM_BYTES)) || xDisplay;
  assign xMiss    = (xWr || xRd) && !xHit;
  assign xWe      = xWr && xHit;

  cdma_dataram uRam (
    .sys_clk (sys_clk),
    .iWe     (iWe),
    .iAddr   (ramAddr),
    .iWdata  (pushReq ? dWdata : dWdata),
    .iRdata  (iRdata),
    .xWe     (xWe),
    .xIdx    (xAddr[XIDX_W-1:0]),
    .xWdata  (xWdata),
    .xRdata  (xRam)
  );
  assign xRdata = xRam;

  // register read mux; addresses owned elsewhere read zero here
  always_comb begin
    sfrRd     = 8'h00;
    dSfrOther = 1'b0;
    unique case (dAddr)
      SFR_ACC:    sfrRd = acc_q;
      SFR_B:      sfrRd = b_q;
      SFR_PSW:    sfrRd = {psw_q[7:1], parity};
      SFR_SP:     sfrRd = sp_q;
      SFR_DPL:    sfrRd = dpl_q;
      SFR_DPH:    sfrRd = dph_q;
      SFR_SECOND_POINTER_LOW:   sfrRd = second_pointer_low_q;
      SFR_SECOND_POINTER_HIGH:   sfrRd = second_pointer_high_q;
      SFR_INSCFG: sfrRd = cfg_q;
      SFR_AUX:    sfrRd = aux_q;
      SFR_EXTERNAL_RAM_PAGE:  sfrRd = external_ram_page_q;
      default:    dSfrOther = dSfr && (dRd || dWr);
    endcase
  end

  // read data steering, one cycle after the request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fromSfr_q <= 1'b0;
      sfrRd_q   <= 8'h00;
    end else begin
      fromSfr_q <= dSfr && !pushReq && !popReq;
      sfrRd_q   <= sfrRd;
    end
  end
  assign dRdata = fromSfr_q ? sfrRd_q : iRdata;

  // accumulator: operations win over a register write in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 8'h00;
    end else if (mulReq) begin
      acc_q <= md.mA;
    end else if (divReq) begin
      acc_q <= md.dA;
    end else if (addReq) begin
      acc_q <= sum[7:0];
    end else if (dWr && dSfr && dAddr == SFR_ACC) begin
      acc_q <= dWdata;
    end
  end

  // B register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      b_q <= 8'h00;
    end else if (mulReq) begin
      b_q <= md.mB;
    end else if (divReq) begin
      b_q <= md.dB;
    end else if (dWr && dSfr && dAddr == SFR_B) begin
      b_q <= dWdata;
    end
  end

  // aux register: narrow operations hand back its old value
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_q <= 8'h00;
    end else if (mulReq) begin
      aux_q <= md.mX;
    end else if (divReq) begin
      aux_q <= md.dX;
    end else if (dWr && dSfr && dAddr == SFR_AUX) begin
      aux_q <= dWdata;
    end
  end

  // status word; parity is never stored, it is derived on read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      psw_q <= PSW_RST;
    end else if (mulReq || divReq) begin
      psw_q[PSW_CY] <= 1'b0;
      psw_q[PSW_OV] <= mulReq ? md.mOv : md.dOv;
    end else if (addReq) begin
      psw_q[PSW_CY] <= sum[8];
      psw_q[PSW_AC] <= lowSum[4];
      psw_q[PSW_OV] <= addOv;
    end else if (dWr && dSfr && dAddr == SFR_PSW) begin
      psw_q <= dWdata & PSW_WMASK;
    end
  end

  // stack pointer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_q <= SP_RST;
    end else if (pushReq) begin
      sp_q <= spInc;
    end else if (popReq) begin
      sp_q <= sp_q - 8'h01;
    end else if (dWr && dSfr && dAddr == SFR_SP) begin
      sp_q <= dWdata;
    end
  end

  // first pointer, bytewise or incremented as a whole
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dpl_q <= 8'h00;
      dph_q <= 8'h00;
    end else if (dptrInc && !cfg_q[CFG_PSEL]) begin
      {dph_q, dpl_q} <= ptrNext;
    end else if (dWr && dSfr) begin
      if (dAddr == SFR_DPL) begin
        dpl_q <= dWdata;
      end
      if (dAddr == SFR_DPH) begin
        dph_q <= dWdata;
      end
    end
  end

  // second pointer, same structure
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      second_pointer_low_q <= 8'h00;
      second_pointer_high_q <= 8'h00;
    end else if (dptrInc && cfg_q[CFG_PSEL]) begin
      {second_pointer_high_q, second_pointer_low_q} <= ptrNext;
    end else if (dWr && dSfr) begin
      if (dAddr == SFR_SECOND_POINTER_LOW) begin
        second_pointer_low_q <= dWdata;
      end
      if (dAddr == SFR_SECOND_POINTER_HIGH) begin
        second_pointer_high_q <= dWdata;
      end
    end
  end

  // config and page registers; unimplemented bits are masked off so they read zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q   <= CFG_RST;
      external_ram_page_q <= EXTERNAL_RAM_PAGE_RST;
    end else if (dWr && dSfr) begin
      if (dAddr == SFR_INSCFG) begin
        cfg_q <= dWdata & CFG_MASK;
      end
      if (dAddr == SFR_EXTERNAL_RAM_PAGE) begin
        external_ram_page_q <= dWdata & EXTERNAL_RAM_PAGE_MASK;
      end
    end
  end

  // checks
  a_parity_view: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pswOut[PSW_P] == ^accOut) else $error("parity flag wrong");
  a_mul_narrow: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mulReq && !cfg_q[CFG_MULW] |=> {b_q, acc_q} == 16'($past(acc_q) * $past(b_q))
    && aux_q == $past(aux_q)) else $error("narrow multiply wrong");
  a_mul_wide: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mulReq && cfg_q[CFG_MULW] |=> {aux_q, b_q, acc_q} ==
    24'({$past(aux_q), $past(acc_q)} * $past(b_q))) else $error("wide multiply wrong");
  a_div_narrow: assert property (@(posedge sys_clk) disable iff (!arst_n)
    divReq && !cfg_q[CFG_DIVW] && b_q != 8'h00 |=> acc_q == $past(acc_q) / $past(b_q)
    && b_q == $past(acc_q) % $past(b_q)) else $error("narrow divide wrong");
  a_div_wide: assert property (@(posedge sys_clk) disable iff (!arst_n)
    divReq && cfg_q[CFG_DIVW] && b_q != 8'h00 |=> {aux_q, acc_q} ==
    16'({$past(aux_q), $past(acc_q)} / $past(b_q))) else $error("wide divide wrong");
  a_stack_push: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pushReq ##1 popReq |=> sp_q == $past(sp_q, 2)) else $error("stack pointer drift");
  a_ptr_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dptrInc |=> dptr == $past(dptr) + 16'h0001) else $error("pointer increment wrong");
  a_page_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (xWr || xRd) && !xViaPtr |-> xAddr[15] == 1'b0 && xAddr[7:0] == xRi)
    else $error("paged address wrong");
  a_mode_split: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dWr && dIndirect |=> $stable(cfg_q) && $stable(acc_q) || $past(mulReq || divReq
    || addReq)) else $error("indirect write reached a register");
  a_add_ovf: assert property (@(posedge sys_clk) disable iff (!arst_n)
    addReq && !mulReq && !divReq && acc_q == 8'h7F && addOperand == 8'h01
    |=> pswOut[PSW_OV] && acc_q == 8'h80) else $error("overflow flag missed");
  c_wide_mul: cover property (@(posedge sys_clk) disable iff (!arst_n)
    mulReq && cfg_q[CFG_MULW]);
  c_wide_div: cover property (@(posedge sys_clk) disable iff (!arst_n)
    divReq && cfg_q[CFG_DIVW] && aux_q != 8'h00);
  c_display: cover property (@(posedge sys_clk) disable iff (!arst_n) xWr && xDisplay);
  c_push_pop: cover property (@(posedge sys_clk) disable iff (!arst_n) pushReq ##1 popReq);
endmodule // cdma_top

// [bench/cdma_top_tb.sv]
// Purpose: self-checking bench for the datapath and data-memory addressing block
// Assumes: inputs change 2 ns after the rising edge; read data lands one cycle after the strobe
// Notes:   each scenario is its own task; one watchdog bounds the whole run
`timescale 1ns/1ps
module cdma_top_tb;
  import cdma_pkg::*;
  // clock, reset and design ports
  logic        sys_clk, arst_n;
  logic [7:0]  dAddr, dWdata, dRdata, wrAddr, xRi, xWdata, xRdata, addOperand, accOut, pswOut;
  logic        dIndirect, dWr, dRd, dSfrOther, sfrPage, pushReq, popReq;
  logic [2:0]  wrIdx;
  logic        xWr, xRd, xViaPtr, xMiss, xDisplay;
  logic [15:0] xAddr, dptr;
  logic        mulReq, divReq, addReq, addWithCarry, dptrInc;
  int          badCount, checks;

  cdma_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .dAddr(dAddr), .dIndirect(dIndirect),
    .dWr(dWr), .dRd(dRd), .dWdata(dWdata), .dRdata(dRdata), .dSfrOther(dSfrOther),
    .sfrPage(sfrPage), .wrIdx(wrIdx), .wrAddr(wrAddr), .pushReq(pushReq), .popReq(popReq),
    .xWr(xWr), .xRd(xRd), .xViaPtr(xViaPtr), .xRi(xRi), .xWdata(xWdata), .xAddr(xAddr),
    .xRdata(xRdata), .xMiss(xMiss), .xDisplay(xDisplay), .mulReq(mulReq), .divReq(divReq),
    .addReq(addReq), .addOperand(addOperand), .addWithCarry(addWithCarry),
    .dptrInc(dptrInc), .dptr(dptr), .accOut(accOut), .pswOut(pswOut));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // step to just after the next rising edge so driven values never race the edge
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic ind, input logic [7:0] v);
    dAddr = a; dIndirect = ind; dWdata = v; dWr = 1'b1;
    tick();
    dWr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic ind, output logic [7:0] v);
    dAddr = a; dIndirect = ind; dRd = 1'b1;
    tick();
    dRd = 1'b0;
    v = dRdata;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic ind,
                       input logic [7:0] exp);
    logic [7:0] v;
    rd(a, ind, v);
    chk(what, {8'h00, exp}, {8'h00, v});
  endtask

  // pulse one operation request for a single cycle
  task automatic op(input int k);
    case (k)
      0: mulReq = 1'b1;
      1: divReq = 1'b1;
      2: addReq = 1'b1;
      default: dptrInc = 1'b1;
    endcase
    tick();
    {mulReq, divReq, addReq, dptrInc} = 4'h0;
  endtask

  // external move; address flags are sampled while the strobe is up
  task automatic xmove(input logic wrt, input logic ptr, input logic [7:0] ri,
                       input logic [7:0] v, input logic [15:0] expAddr, input logic expDisp);
    xViaPtr = ptr; xRi = ri; xWdata = v; xWr = wrt; xRd = ~wrt;
    #1;
    chk("xAddr", expAddr, xAddr);
    chk("xDisplay", {15'h0000, expDisp}, {15'h0000, xDisplay});
    tick();
    {xWr, xRd} = 2'b00;
  endtask

  task automatic t_reset();
    rdchk("sp", SFR_SP, 1'b0, 8'h07);
    rdchk("psw", SFR_PSW, 1'b0, 8'h00);
    rdchk("cfg", SFR_INSCFG, 1'b0, 8'h00);
    rdchk("external_ram_page", SFR_EXTERNAL_RAM_PAGE, 1'b0, 8'h00);
    chk("sfrPage", 16'h0000, {15'h0000, sfrPage});
  endtask

  task automatic t_bank();
    for (int b = 0; b < 4; b++) begin
      wr(SFR_PSW, 1'b0, 8'(b << 3));
      wrIdx = 3'h5;
      #1;
      chk("wrAddr", 16'(b * 8 + 5), {8'h00, wrAddr});
    end
  endtask

  task automatic t_parity();
    logic [7:0] vals [4] = '{8'h00, 8'h01, 8'hFF, 8'h7F};
    foreach (vals[i]) begin
      wr(SFR_ACC, 1'b0, vals[i]);
      chk("parity", {15'h0000, ^vals[i]}, {15'h0000, pswOut[PSW_P]});
    end
  endtask

  task automatic t_muldiv();
    // narrow multiply: aux must stay a plain scratch byte
    wr(SFR_AUX, 1'b0, 8'h99);
    rdchk("auxScratch", SFR_AUX, 1'b0, 8'h99);
    wr(SFR_ACC, 1'b0, 8'hC8);
    wr(SFR_B, 1'b0, 8'h03);
    op(0);
    rdchk("mulA", SFR_ACC, 1'b0, 8'h58);
    rdchk("mulB", SFR_B, 1'b0, 8'h02);
    rdchk("mulAux", SFR_AUX, 1'b0, 8'h99);
    // wide multiply 1234H * 56H = 61D78H
    wr(SFR_INSCFG, 1'b0, 8'h04);
    wr(SFR_AUX, 1'b0, 8'h12);
    wr(SFR_ACC, 1'b0, 8'h34);
    wr(SFR_B, 1'b0, 8'h56);
    op(0);
    rdchk("wmulA", SFR_ACC, 1'b0, 8'h78);
    rdchk("wmulB", SFR_B, 1'b0, 8'h1D);
    rdchk("wmulAux", SFR_AUX, 1'b0, 8'h06);
    // narrow divide 100 / 7
    wr(SFR_INSCFG, 1'b0, 8'h00);
    wr(SFR_ACC, 1'b0, 8'h64);
    wr(SFR_B, 1'b0, 8'h07);
    op(1);
    rdchk("divA", SFR_ACC, 1'b0, 8'h0E);
    rdchk("divB", SFR_B, 1'b0, 8'h02);
    // wide divide 1234H / 10H
    wr(SFR_INSCFG, 1'b0, 8'h08);
    wr(SFR_AUX, 1'b0, 8'h12);
    wr(SFR_ACC, 1'b0, 8'h34);
    wr(SFR_B, 1'b0, 8'h10);
    op(1);
    rdchk("wdivA", SFR_ACC, 1'b0, 8'h23);
    rdchk("wdivB", SFR_B, 1'b0, 8'h04);
    rdchk("wdivAux", SFR_AUX, 1'b0, 8'h01);
  endtask

  task automatic t_ovf();
    wr(SFR_ACC, 1'b0, 8'h7F);
    addOperand = 8'h01;
    op(2);
    chk("ovSet", 16'h0001, {15'h0000, pswOut[PSW_OV]});
    wr(SFR_ACC, 1'b0, 8'h01);
    op(2);
    chk("ovClr", 16'h0000, {15'h0000, pswOut[PSW_OV]});
    // add with carry: FFH + 01H leaves a carry that the next add folds in
    wr(SFR_ACC, 1'b0, 8'hFF);
    op(2);
    addOperand = 8'h00;
    addWithCarry = 1'b1;
    op(2);
    addWithCarry = 1'b0;
    rdchk("addCarry", SFR_ACC, 1'b0, 8'h01);
  endtask

  task automatic t_ptr();
    wr(SFR_DPL, 1'b0, 8'h34);
    wr(SFR_DPH, 1'b0, 8'h12);
    wr(SFR_SECOND_POINTER_LOW, 1'b0, 8'hCD);
    wr(SFR_SECOND_POINTER_HIGH, 1'b0, 8'hAB);
    chk("dptr0", 16'h1234, dptr);
    wr(SFR_INSCFG, 1'b0, 8'hFF);
    rdchk("cfgMask", SFR_INSCFG, 1'b0, 8'h4D);
    chk("page1", 16'h0001, {15'h0000, sfrPage});
    chk("second_data_pointer", 16'hABCD, dptr);
    op(3);
    chk("dptr1Inc", 16'hABCE, dptr);
    wr(SFR_INSCFG, 1'b0, 8'h00);
    chk("dptrBack", 16'h1234, dptr);
  endtask

  task automatic t_space();
    wr(8'h30, 1'b0, 8'hA1);
    rdchk("lowInd", 8'h30, 1'b1, 8'hA1);
    wr(SFR_B, 1'b0, 8'h3C);
    wr(SFR_B, 1'b1, 8'h55);
    rdchk("upperRam", SFR_B, 1'b1, 8'h55);
    rdchk("sfrKept", SFR_B, 1'b0, 8'h3C);
    dAddr = 8'h90; dIndirect = 1'b0; dRd = 1'b1;
    #1;
    chk("other", 16'h0001, {15'h0000, dSfrOther});
    tick();
    dRd = 1'b0;
  endtask

  task automatic t_stack();
    dWdata = 8'h11; pushReq = 1'b1;
    tick();
    dWdata = 8'h22;
    tick();
    pushReq = 1'b0;
    rdchk("spPush", SFR_SP, 1'b0, 8'h09);
    rdchk("stackLo", 8'h08, 1'b1, 8'h11);
    popReq = 1'b1;
    tick();
    popReq = 1'b0;
    chk("popData", 16'h0022, {8'h00, dRdata});
    rdchk("spPop", SFR_SP, 1'b0, 8'h08);
  endtask

  task automatic t_xram();
    wr(SFR_EXTERNAL_RAM_PAGE, 1'b0, 8'hFF);
    rdchk("xpageMask", SFR_EXTERNAL_RAM_PAGE, 1'b0, 8'h7F);
    wr(SFR_EXTERNAL_RAM_PAGE, 1'b0, 8'h05);
    wr(SFR_DPH, 1'b0, 8'h05);
    wr(SFR_DPL, 1'b0, 8'h10);
    xmove(1'b1, 1'b1, 8'h00, 8'h6B, 16'h0510, 1'b1);
    xmove(1'b0, 1'b0, 8'h10, 8'h00, 16'h0510, 1'b1);
    chk("xReadBack", 16'h006B, {8'h00, xRdata});
    wr(SFR_EXTERNAL_RAM_PAGE, 1'b0, 8'h04);
    xmove(1'b1, 1'b0, 8'hFF, 8'hE4, 16'h04FF, 1'b0);
    wr(SFR_DPH, 1'b0, 8'h04);
    wr(SFR_DPL, 1'b0, 8'hFF);
    xmove(1'b0, 1'b1, 8'h00, 8'h00, 16'h04FF, 1'b0);
    chk("xTopRam", 16'h00E4, {8'h00, xRdata});
    wr(SFR_DPH, 1'b0, 8'h05);
    wr(SFR_DPL, 1'b0, 8'h1C);
    xRd = 1'b1; xViaPtr = 1'b1;
    #1;
    chk("xMiss", 16'h0001, {15'h0000, xMiss});
    tick();
    xRd = 1'b0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: a run that overstays counts as a mismatch
  initial begin
    repeat (5000) @(posedge sys_clk);
    badCount++;
    give_verdict();
  end

  // main sequence
  initial begin
    arst_n = 1'b0; dAddr = 8'h00; dIndirect = 1'b0; dWr = 1'b0; dRd = 1'b0;
    dWdata = 8'h00; wrIdx = 3'h0; pushReq = 1'b0; popReq = 1'b0; xWr = 1'b0;
    xRd = 1'b0; xViaPtr = 1'b0; xRi = 8'h00; xWdata = 8'h00; mulReq = 1'b0;
    divReq = 1'b0; addReq = 1'b0; addOperand = 8'h00; addWithCarry = 1'b0;
    dptrInc = 1'b0; badCount = 0; checks = 0;
    repeat (8) @(posedge sys_clk);
    #2;
    arst_n = 1'b1;
    t_reset();
    t_bank();
    t_parity();
    t_muldiv();
    t_ovf();
    t_ptr();
    t_space();
    t_stack();
    t_xram();
    give_verdict();
  end
endmodule // cdma_top_tb
